// file: verilog/svp_defs.svh
`ifndef SVP_DEFS_SVH
`define SVP_DEFS_SVH
// Clock and switching timebase
`define SVP_CLK_PERIOD_NS 25
`define SVP_CLK_KHZ (1000000 / `SVP_CLK_PERIOD_NS)
`define SVP_FSW_KHZ 250
`define SVP_SAMPLES 6
`define SVP_SUB_CLKS ((`SVP_CLK_KHZ / `SVP_FSW_KHZ) / `SVP_SAMPLES)
`define SVP_HALF_WAIT 3'h3
// Soft-start counts, in switching cycles
`define SVP_SS_DELAY 64
`define SVP_SS_COARSE 640
`define SVP_COARSE_PER 32
`define SVP_FINE_PER 16
`define SVP_OFS_PER 80
`define SVP_NL_CYC 2
// Levels in 12.5mV units
`define SVP_OFS_INIT 4'h8
`define SVP_OV_FLOOR 8'h88
`define SVP_OV_MARGIN 8'h10
`define SVP_COARSE_STEP 8'h02
`define SVP_FINE_STEP 8'h01
// Code to level mapping
`define SVP_CODE_WRAP 6'h15
`define SVP_BASE_HI 8'h95
`define SVP_BASE_LO 8'h57
`define SVP_NL_PREFIX 5'h1F
`define SVP_CODE_RST 6'h3F
// Register map
`define SVP_ADDR_CTRL 32'h0000_0000
`define SVP_ADDR_STATUS 32'h0000_0004
`define SVP_ADDR_LEVEL 32'h0000_0008
`define SVP_CTRL_RST 1'b1
`endif

// file: verilog/svp_pkg.sv
package svp_pkg;
	typedef enum logic [2:0] {
		SVP_SHUT,
		SVP_DELAY,
		SVP_RAMP,
		SVP_RUN,
		SVP_NLWAIT
	} svp_state_t;

	typedef struct packed {
		logic       pok;
		logic       pwm_on;
		logic       ov_latch;
		logic       uv;
		svp_state_t state;
	} svp_status_t;
endpackage

// file: verilog/svp_sequencer.sv
`timescale 1ns/100ps
`include "svp_defs.svh"

module svp_sequencer
	import svp_pkg::*;
#(
	parameter int unsigned SUB_CLKS   = `SVP_SUB_CLKS,
	parameter int unsigned SS_DELAY   = `SVP_SS_DELAY,
	parameter int unsigned SS_COARSE  = `SVP_SS_COARSE,
	parameter int unsigned COARSE_PER = `SVP_COARSE_PER,
	parameter int unsigned FINE_PER   = `SVP_FINE_PER,
	parameter int unsigned OFS_PER    = `SVP_OFS_PER,
	parameter int unsigned NL_CYC     = `SVP_NL_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        bias_valid,
	input  wire logic        threshold_enable,
	input  wire logic        logic_enable,
	input  wire logic [4:0]  voltage_code,
	input  wire logic        half_step_bit,
	input  wire logic [7:0]  sense_voltage,
	input  wire logic        ov_detect,
	output logic             pwm_oe_n,
	output logic [7:0]       dac_level,
	output logic [3:0]       sense_offset,
	output logic [7:0]       ov_trip_level,
	output logic             power_ok_out,
	output logic             power_ok_oe_n
);
	localparam int unsigned SUB_W = $clog2(SUB_CLKS + 1);

	logic             core_rst_n;
	logic [SUB_W-1:0] sub_cnt;
	logic [2:0]       phase;
	logic             strobe;
	logic             cyc_tick;
	logic [5:0]       code_q;
	logic [7:0]       tgt;
	logic             noload;
	logic             uv;
	logic             run_allow;
	logic             ov_latch;
	logic             enables_ok;
	logic             en_ok;
	svp_state_t       state;
	svp_state_t       next_state;
	logic [11:0]      ss_cyc;
	logic [5:0]       step_cnt;
	logic [6:0]       ofs_cnt;
	logic             coarse;
	logic             ramp_step;
	logic             pend;
	logic             pend_up;
	logic [2:0]       wait_cnt;
	logic             diff_up;
	logic             diff_dn;
	logic             far;
	logic [7:0]       ov_code;
	logic             acc;
	logic             wr_pend;
	logic [31:0]      wr_addr;
	logic             ctrl_now;
	logic [31:0]      rd_val;
	svp_status_t      status;

	////////////////////////////////////////////////////////////////////////
	// Bias loss acts as an asynchronous reset of the sequencer core; the AHB registers reset on hresetn only
	assign core_rst_n = hresetn & bias_valid;

	// Switching cycle split into six equal sixths
	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			sub_cnt <= '0;
			phase <= '0;
		end else if (clk_en) begin
			if (sub_cnt == SUB_W'(SUB_CLKS - 1)) begin
				sub_cnt <= '0;
				phase <= (phase == 3'(`SVP_SAMPLES - 1)) ? 3'h0 : phase + 3'h1;
			end else begin
				sub_cnt <= sub_cnt + SUB_W'(1);
			end
		end
	end

	assign strobe   = clk_en && (sub_cnt == SUB_W'(SUB_CLKS - 1));
	assign cyc_tick = strobe && (phase == 3'(`SVP_SAMPLES - 1));

	// Code captured on each strobe; reset value reads as no-load
	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			code_q <= `SVP_CODE_RST;
		end else if (strobe) begin
			code_q <= {voltage_code, half_step_bit};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Code to level (12.5mV units); the table wraps at code 21
	always_comb begin
		if (code_q >= `SVP_CODE_WRAP) begin
			tgt = `SVP_BASE_HI - {2'b00, code_q};
		end else begin
			tgt = `SVP_BASE_LO - {2'b00, code_q};
		end
	end

	assign noload = (code_q[5:1] == `SVP_NL_PREFIX);
	// 4*sense < 3*target, kept in integers to avoid a divider
	assign uv = {sense_voltage, 2'b00} < (10'({tgt, 1'b0}) + 10'(tgt));
	assign enables_ok = threshold_enable && logic_enable && run_allow;
	assign en_ok = enables_ok && !noload && !ov_latch;

	// Overvoltage latch; set wins over the enable-driven clear
	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			ov_latch <= 1'b0;
		end else if (clk_en) begin
			if (ov_detect) begin
				ov_latch <= 1'b1;
			end else if (!threshold_enable || !logic_enable) begin
				ov_latch <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer state
	always_comb begin
		next_state = state;
		case (state)
			SVP_SHUT: begin
				if (en_ok) begin
					next_state = SVP_DELAY;
				end
			end
			SVP_DELAY, SVP_RAMP, SVP_RUN: begin
				if (!enables_ok || ov_latch) begin
					next_state = SVP_SHUT;
				end else if (noload) begin
					next_state = SVP_NLWAIT;
				end else if (state == SVP_DELAY && cyc_tick && ss_cyc == 12'(SS_DELAY - 1)) begin
					next_state = SVP_RAMP;
				end else if (state == SVP_RAMP && dac_level >= tgt) begin
					next_state = SVP_RUN;
				end
			end
			SVP_NLWAIT: begin
				if (!enables_ok || ov_latch) begin
					next_state = SVP_SHUT;
				end else if (cyc_tick && ss_cyc == 12'(NL_CYC - 1)) begin
					next_state = SVP_SHUT;
				end
			end
			default: next_state = SVP_SHUT;
		endcase
	end

	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			state <= SVP_SHUT;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// Cycle counter, restarted on every state change
	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			ss_cyc <= '0;
		end else if (clk_en) begin
			if (next_state != state) begin
				ss_cyc <= '0;
			end else if (cyc_tick && ss_cyc != 12'hFFF) begin
				ss_cyc <= ss_cyc + 12'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Ramp pacing: same slope in both halves, step size differs
	assign coarse = (ss_cyc < 12'(SS_COARSE));

	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			step_cnt <= '0;
		end else if (clk_en) begin
			if (state != SVP_RAMP || next_state != state) begin
				step_cnt <= '0;
			end else if (ramp_step) begin
				step_cnt <= '0;
			end else if (cyc_tick) begin
				step_cnt <= step_cnt + 6'h01;
			end
		end
	end

	assign ramp_step = (state == SVP_RAMP) && cyc_tick &&
		(step_cnt == (coarse ? 6'(COARSE_PER - 1) : 6'(FINE_PER - 1)));

	assign diff_up = tgt > dac_level;
	assign diff_dn = tgt < dac_level;
	assign far     = diff_up ? (tgt - dac_level > 8'h01) : (dac_level - tgt > 8'h01);

	// DAC level: zero when idle, ramped, then tracks the code
	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			dac_level <= '0;
			pend <= 1'b0;
			pend_up <= 1'b0;
			wait_cnt <= '0;
		end else if (clk_en) begin
			if (state == SVP_SHUT || state == SVP_DELAY) begin
				dac_level <= '0;
				pend <= 1'b0;
			end else if (state == SVP_RAMP) begin
				pend <= 1'b0;
				if (ramp_step && diff_up) begin
					if (coarse && far) begin
						dac_level <= dac_level + `SVP_COARSE_STEP;
					end else begin
						dac_level <= dac_level + `SVP_FINE_STEP;
					end
				end
			end else if (strobe) begin
				if (far) begin
					pend <= 1'b0;
					dac_level <= diff_up ? dac_level + `SVP_FINE_STEP : dac_level - `SVP_FINE_STEP;
				end else if (pend) begin
					if (pend_up ? !diff_up : !diff_dn) begin
						pend <= 1'b0;
					end else if (wait_cnt == 3'h1) begin
						pend <= 1'b0;
						dac_level <= pend_up ? dac_level + `SVP_FINE_STEP : dac_level - `SVP_FINE_STEP;
					end else begin
						wait_cnt <= wait_cnt - 3'h1;
					end
				end else if (diff_up || diff_dn) begin
					pend <= 1'b1;
					pend_up <= diff_up;
					wait_cnt <= `SVP_HALF_WAIT;
				end
			end
		end
	end

	// Sense offset: full at entry, one unit per OFS_PER ramp cycles
	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			sense_offset <= '0;
			ofs_cnt <= '0;
		end else if (clk_en) begin
			if (state == SVP_DELAY) begin
				sense_offset <= `SVP_OFS_INIT;
				ofs_cnt <= '0;
			end else if (state != SVP_RAMP) begin
				sense_offset <= '0;
				ofs_cnt <= '0;
			end else if (cyc_tick && sense_offset != 4'h0) begin
				if (ofs_cnt == 7'(OFS_PER - 1)) begin
					ofs_cnt <= '0;
					sense_offset <= sense_offset - 4'h1;
				end else begin
					ofs_cnt <= ofs_cnt + 7'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PWM enable; during the ramp it latches once the DAC meets the output
	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			pwm_oe_n <= 1'b1;
		end else if (clk_en) begin
			case (state)
				SVP_RUN, SVP_NLWAIT: pwm_oe_n <= 1'b0;
				SVP_RAMP: begin
					if (dac_level >= sense_voltage) begin
						pwm_oe_n <= 1'b0;
					end
				end
				default: pwm_oe_n <= 1'b1;
			endcase
		end
	end

	// Power ok: overvoltage is deliberately not an input here
	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			power_ok_oe_n <= 1'b0;
		end else if (clk_en) begin
			power_ok_oe_n <= (state == SVP_RUN) && !uv;
		end
	end

	assign power_ok_out = 1'b0;

	// Overvoltage trip level
	assign ov_code = tgt + `SVP_OV_MARGIN;

	always_ff @(posedge hclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			ov_trip_level <= `SVP_OV_FLOOR;
		end else if (clk_en) begin
			case (state)
				SVP_SHUT: ov_trip_level <= ov_latch ? ov_code : `SVP_OV_FLOOR;
				SVP_DELAY, SVP_RAMP: ov_trip_level <= (ov_code > `SVP_OV_FLOOR) ? ov_code : `SVP_OV_FLOOR;
				default: ov_trip_level <= ov_code;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states; clk_en low stalls the bus
	assign hreadyout = clk_en;
	assign hresp     = 1'b0;
	assign acc       = hsel && hready && htrans[1] && clk_en;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
			run_allow <= `SVP_CTRL_RST;
		end else if (clk_en) begin
			if (wr_pend && wr_addr == `SVP_ADDR_CTRL) begin
				run_allow <= hwdata[0];
			end
			wr_pend <= acc && hwrite;
			wr_addr <= haddr;
		end
	end

	// A read right behind a control write sees the new value
	assign ctrl_now = (wr_pend && wr_addr == `SVP_ADDR_CTRL) ? hwdata[0] : run_allow;

	always_comb begin
		status.pok = power_ok_oe_n;
		status.pwm_on = !pwm_oe_n;
		status.ov_latch = ov_latch;
		status.uv = uv;
		status.state = state;
	end

	// Unmapped addresses read zero and still answer OKAY
	always_comb begin
		if (haddr == `SVP_ADDR_CTRL) begin
			rd_val = {31'h0000_0000, ctrl_now};
		end else if (haddr == `SVP_ADDR_STATUS) begin
			rd_val = {25'h000_0000, status};
		end else if (haddr == `SVP_ADDR_LEVEL) begin
			rd_val = {12'h000, sense_offset, tgt, dac_level};
		end else begin
			rd_val = 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (acc && !hwrite) begin
			hrdata <= rd_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!core_rst_n);

	shut_hiz_a: assert property ((clk_en && state == SVP_SHUT) |=> pwm_oe_n)
		else $error("PWM driven in shutdown");
	pok_shut_a: assert property ((clk_en && state != SVP_RUN) |=> !power_ok_oe_n)
		else $error("power ok released outside run");
	pok_uv_a: assert property ((clk_en && uv) |=> !power_ok_oe_n)
		else $error("power ok released under undervoltage");
	pok_run_a: assert property ((clk_en && state == SVP_RUN && !uv) |=> power_ok_oe_n)
		else $error("power ok low in healthy run");
	start_now_a: assert property ((clk_en && state == SVP_SHUT && en_ok) |=> state == SVP_DELAY)
		else $error("soft-start not entered at once");
	delay_end_a: assert property ((state == SVP_DELAY && clk_en && enables_ok && !noload && !ov_latch
		&& cyc_tick && ss_cyc == 12'(SS_DELAY - 1)) |=> state == SVP_RAMP)
		else $error("delay length wrong");
	delay_zero_a: assert property ((state == SVP_DELAY) |-> ##1 (dac_level == 8'h00))
		else $error("DAC not zero during delay");
	track_step_a: assert property ((clk_en && state == SVP_RUN && !strobe) |=> $stable(dac_level))
		else $error("DAC moved between strobes");
	one_step_a: assert property ((state == SVP_RUN && !far) |=> (dac_level == $past(dac_level) ||
		dac_level == $past(dac_level) + 8'h01 || dac_level == $past(dac_level) - 8'h01))
		else $error("tracking step larger than one unit");
	ov_hold_a: assert property ((ov_latch && threshold_enable && logic_enable) |=> ov_latch)
		else $error("overvoltage latch cleared");
	six_phase_a: assert property ((strobe && phase == 3'h5) |=> phase == 3'h0)
		else $error("phase did not wrap after six");
endmodule

// file: testbench/svp_partner.sv
`timescale 1ns/100ps
module svp_partner #(
	parameter logic [7:0]  PREBIAS = 8'h10,
	parameter int unsigned PACE    = 24
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [5:0] cmd_code,
	input  wire logic       jump,
	input  wire logic       uv_drop,
	input  wire logic       pwm_oe_n,
	input  wire logic [7:0] dac_level,
	output logic [4:0]      voltage_code,
	output logic            half_step_bit,
	output logic [7:0]      sense_voltage
);
	logic [5:0]  code;
	int unsigned pace;

	assign {voltage_code, half_step_bit} = code;

	////////////////////////////////////////////////////////////
	// Processor side: one code step per PACE+1 clocks; a jump loads cmd_code at once, for any step size
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			code <= 6'h3F;
			pace <= 0;
		end else if (jump) begin
			code <= cmd_code;
		end else if (pace != 0) begin
			pace <= pace - 1;
		end else if (code != cmd_code) begin
			code <= (code < cmd_code) ? code + 6'h01 : code - 6'h01;
			pace <= PACE;
		end
	end

	////////////////////////////////////////////////////////////
	// Output node keeps its charge while the drivers are off, so a pre-bias survives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sense_voltage <= PREBIAS;
		end else if (uv_drop) begin
			sense_voltage <= 8'h20;
		end else if (!pwm_oe_n) begin
			sense_voltage <= dac_level;
		end
	end
endmodule

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
	import svp_pkg::*;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, jump = 1, uv_drop = 0;
	logic        bias_valid = 1, threshold_enable = 1, logic_enable = 1, ov_detect = 0, clk_en = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [5:0]  cmd_code = 6'h3F;
	logic [4:0]  voltage_code;
	logic [7:0]  sense_voltage, dac_level, ov_trip_level;
	logic [3:0]  sense_offset;
	logic        half_step_bit, hreadyout, hresp, pwm_oe_n, power_ok_out, power_ok_oe_n;
	int          n_errors = 0, n_checks = 0, cnt;

	svp_sequencer #(.SUB_CLKS(2), .SS_DELAY(4), .SS_COARSE(8), .COARSE_PER(2), .FINE_PER(1), .OFS_PER(1),
		.NL_CYC(2)) uut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bias_valid(bias_valid),
		.threshold_enable(threshold_enable), .logic_enable(logic_enable), .voltage_code(voltage_code),
		.half_step_bit(half_step_bit), .sense_voltage(sense_voltage), .ov_detect(ov_detect),
		.pwm_oe_n(pwm_oe_n), .dac_level(dac_level), .sense_offset(sense_offset),
		.ov_trip_level(ov_trip_level), .power_ok_out(power_ok_out), .power_ok_oe_n(power_ok_oe_n));
	svp_partner prt (.hclk(hclk), .hresetn(hresetn), .cmd_code(cmd_code), .jump(jump), .uv_drop(uv_drop),
		.pwm_oe_n(pwm_oe_n), .dac_level(dac_level), .voltage_code(voltage_code),
		.half_step_bit(half_step_bit), .sense_voltage(sense_voltage));

	// 40 MHz clock
	always #12.5 hclk = ~hclk;

	////////////////////////////////////////////////////////////
	// Single word transfer; waits on hready with no assumed latency
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task clks(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Waits for soft-start entry, which loads the full sense offset
	task wofs;
		cnt = 0;
		while (sense_offset !== 4'h8 && cnt < 200) begin @(posedge hclk); cnt++; end
		chk(sense_offset, 4'h8);
	endtask
	task wdac(input logic [7:0] v, input int lim);
		cnt = 0;
		while (dac_level !== v && cnt < lim) begin @(posedge hclk); cnt++; end
		chk(dac_level, v);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	task t_reset;
		chk({pwm_oe_n, dac_level, sense_offset, ov_trip_level}, {1'b1, 8'h00, 4'h0, 8'h88});
		chk({power_ok_out, power_ok_oe_n}, 2'h0);
		ahb(1'b0, 32'h0000_0000, 32'h0); chk(r, 32'h1);
		ahb(1'b0, 32'h0000_0004, 32'h0); chk(r[2:0], 3'h0);
		ahb(1'b0, 32'h0000_0010, 32'h0); chk(r, 32'h0);
		$display("reset test done");
	endtask
	task t_start;
		@(posedge hclk); cmd_code <= 6'h14;
		wofs;
		clks(2); chk(ov_trip_level, 8'h88);
		cnt = 0;
		while (dac_level === 8'h00 && cnt < 200) begin @(posedge hclk); cnt++; end
		chk(cnt >= 48 && cnt <= 72, 1'b1);
		chk(dac_level, 8'h02);
		cnt = 0;
		while (pwm_oe_n !== 1'b0 && cnt < 2000) begin @(posedge hclk); cnt++; end
		chk(dac_level >= sense_voltage && dac_level != 0, 1'b1);
		wdac(8'h43, 3000);
		clks(3); chk(power_ok_oe_n, 1'b1);
		chk(sense_offset, 4'h0);
		$display("start test done");
	endtask
	task t_track;
		@(posedge hclk); jump <= 1'b0; cmd_code <= 6'h13;
		cnt = 0;
		while ({voltage_code, half_step_bit} !== 6'h13 && cnt < 50) begin @(posedge hclk); cnt++; end
		clks(4); chk(dac_level, 8'h43);
		wdac(8'h44, 40);
		@(posedge hclk); jump <= 1'b1; cmd_code <= 6'h10;
		wdac(8'h47, 20);
		@(posedge hclk); cmd_code <= 6'h0F;
		clks(3); cmd_code <= 6'h10;
		clks(30); chk(dac_level, 8'h47);
		$display("track test done");
	endtask
	task t_uv;
		@(posedge hclk); uv_drop <= 1'b1;
		clks(4); chk({power_ok_oe_n, pwm_oe_n, dac_level}, {2'b00, 8'h47});
		uv_drop <= 1'b0;
		clks(4); chk(power_ok_oe_n, 1'b1);
		// Clock enable low must freeze tracking and stall the bus
		@(posedge hclk); cmd_code <= 6'h0D; clk_en <= 1'b0;
		clks(20); chk({hreadyout, dac_level}, {1'b0, 8'h47});
		clk_en <= 1'b1;
		wdac(8'h4A, 40);
		@(posedge hclk); cmd_code <= 6'h10;
		wdac(8'h47, 40);
		$display("undervoltage test done");
	endtask
	task t_bias;
		@(posedge hclk); bias_valid <= 1'b0;
		#1 chk({dac_level, pwm_oe_n, power_ok_oe_n}, {8'h00, 2'b10});
		@(posedge hclk); bias_valid <= 1'b1;
		wofs;
		$display("bias test done");
	endtask
	task t_ov;
		@(posedge hclk); ov_detect <= 1'b1;
		@(posedge hclk); ov_detect <= 1'b0;
		clks(3); ahb(1'b0, 32'h0000_0004, 32'h0); chk({r[4], r[2:0]}, 4'h8);
		cmd_code <= 6'h3F; clks(30);
		cmd_code <= 6'h10; clks(30);
		ahb(1'b0, 32'h0000_0004, 32'h0); chk({r[4], r[2:0]}, 4'h8);
		logic_enable <= 1'b0;
		ahb(1'b0, 32'h0000_0004, 32'h0); chk(r[2:0], 3'h0);
		logic_enable <= 1'b1;
		wofs;
		threshold_enable <= 1'b0;
		ahb(1'b0, 32'h0000_0004, 32'h0); chk(r[2:0], 3'h0);
		threshold_enable <= 1'b1;
		wofs;
		ahb(1'b1, 32'h0000_0000, 32'h0); ahb(1'b0, 32'h0000_0000, 32'h0); chk(r, 32'h0);
		ahb(1'b0, 32'h0000_0004, 32'h0); chk(r[2:0], 3'h0);
		ahb(1'b1, 32'h0000_0000, 32'h1);
		wofs;
		$display("overvoltage test done");
	endtask
	task t_noload;
		wdac(8'h47, 3000);
		clks(3); chk(power_ok_oe_n, 1'b1);
		cmd_code <= 6'h3E;
		clks(6); chk(pwm_oe_n, 1'b0);
		cnt = 0;
		while (pwm_oe_n !== 1'b1 && cnt < 60) begin @(posedge hclk); cnt++; end
		chk({pwm_oe_n, ov_trip_level}, {1'b1, 8'h88});
		clks(2); chk(power_ok_oe_n, 1'b0);
		cmd_code <= 6'h10;
		wofs;
		$display("no-load test done");
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		clks(4);
		hresetn <= 1'b1;
		t_reset; t_start; t_track; t_uv; t_bias; t_ov; t_noload;
		test_done;
	end
	// Watchdog well beyond the roughly 2200 clocks the sequence needs
	initial begin
		#(25 * 40000);
		n_errors++;
		test_done;
	end
endmodule
